// ===== pkg/touch_timing_pkg.sv
// Constants for the touch timing and click sounder configuration block
package touch_timing_pkg;
  localparam logic [7:0] ADDR_TICK    = 8'h05;
  localparam logic [7:0] ADDR_SAMPLE  = 8'h06;
  localparam logic [7:0] ADDR_SOUNDER = 8'h07;
  localparam logic [7:0] ADDR_SLEEP   = 8'h08;

  localparam logic [7:0] TICK_MASK    = 8'h1f;
  localparam logic [7:0] SAMPLE_MASK  = 8'h3f;
  localparam logic [7:0] SOUNDER_MASK = 8'h07;

  localparam int SND_EN_BIT   = 0;
  localparam int SND_TONE_BIT = 1;
  localparam int SND_LEN_BIT  = 2;

  localparam logic [7:0] TICK_RESET    = 8'h00;
  localparam logic [7:0] SAMPLE_RESET  = 8'h00;
  localparam logic [7:0] SOUNDER_RESET = 8'h00;
  localparam logic [7:0] SLEEP_RESET   = 8'h00;

  localparam int CLK_HZ       = 125000000;
  localparam int TICK_BASE_MS = 5;
  localparam int TONE_LO_HZ   = 1000;
  localparam int TONE_HI_HZ   = 2000;
  localparam int CLICK_SHORT_MS = 10;
  localparam int CLICK_LONG_MS  = 20;
  localparam int IDLE_STEP    = 8;
  localparam int SLEEP_STEP   = 10;
  localparam int SLEEP_MAX    = 100;
  localparam logic [3:0] SLEEP_CODE_MIN = 4'h2;
  localparam logic [3:0] SLEEP_CODE_90  = 4'ha;
  localparam logic [3:0] SLEEP_CODE_100 = 4'hb;
  localparam logic [6:0] SLEEP_DUR_RESET = 7'h0a;

  localparam int MS_CYCLES      = CLK_HZ / 1000;
  localparam int TONE_LO_HALF   = CLK_HZ / (2 * TONE_LO_HZ);
  localparam int TONE_HI_HALF   = CLK_HZ / (2 * TONE_HI_HZ);
endpackage

// ===== verilog/touch_timing_sounder_config.sv
// Timing, sleep and click sounder configuration registers with their timers
`timescale 1ns/100ps
module touch_timing_sounder_config #(
  parameter int MS_CYCLES    = touch_timing_pkg::MS_CYCLES,
  parameter int TONE_LO_HALF = touch_timing_pkg::TONE_LO_HALF,
  parameter int TONE_HI_HALF = touch_timing_pkg::TONE_HI_HALF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  input  wire logic       touchClickEnable,
  input  wire logic       stayAwake,
  input  wire logic       wakePin,
  input  wire logic       activity,
  input  wire logic       rotaryTouch,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  output logic            tickPulse,
  output logic            samplePulse,
  output logic            sounderOut,
  output logic            asleep
);
  logic [7:0]  tickPeriod_reg;
  logic [7:0]  sampleInterval_reg;
  logic [7:0]  sounder_reg;
  logic [7:0]  sleep_reg;
  logic [6:0]  sleepDur_reg;
  logic [31:0] msCount_reg;
  logic        msStrobe_reg;
  logic [5:0]  tickMs_reg;
  logic [5:0]  tickLoad_reg;
  logic [5:0]  sampleCount_reg;
  logic [6:0]  idleCount_reg;
  logic [6:0]  sleepCount_reg;
  logic [31:0] toneCount_reg;
  logic [4:0]  clickMs_reg;
  logic        clicking_reg;
  logic        busOpen;
  logic [6:0]  idleLimit;
  logic        sampleNow;
  logic        idleHold;
  logic        idleExpire;
  logic        sleepDone;
  logic [4:0]  clickLast;
  logic [31:0] toneLast;

  typedef enum logic {PWR_AWAKE, PWR_ASLEEP} powerState_t;
  powerState_t powerState_reg;

  function automatic logic [6:0] sleepLen(input logic [3:0] code, input logic [6:0] prev);
    logic [6:0] res;
    res = prev;
    if (code >= touch_timing_pkg::SLEEP_CODE_MIN && code <= touch_timing_pkg::SLEEP_CODE_90)
      res = 7'((code - 4'h1) * touch_timing_pkg::SLEEP_STEP);
    else if (code == touch_timing_pkg::SLEEP_CODE_100)
      res = 7'(touch_timing_pkg::SLEEP_MAX);
    return res;
  endfunction

  assign busOpen   = !asleep || wakePin;
  assign idleLimit = 7'(sleep_reg[7:4] * touch_timing_pkg::IDLE_STEP);
  assign sampleNow = tickPulse && sampleCount_reg == sampleInterval_reg[5:0];

  // Idle and sleep decisions
  assign idleHold   = activity || stayAwake || sleep_reg == 8'h00 || idleLimit == 7'h0;
  assign idleExpire = !idleHold && sampleNow && idleCount_reg == idleLimit - 7'h1;
  assign sleepDone  = wakePin || (sampleNow && sleepCount_reg == sleepDur_reg - 7'h1);

  // Click length and tone half period
  assign clickLast  = sounder_reg[touch_timing_pkg::SND_LEN_BIT] ? 5'(touch_timing_pkg::CLICK_LONG_MS - 1)
                      : 5'(touch_timing_pkg::CLICK_SHORT_MS - 1);
  assign toneLast   = sounder_reg[touch_timing_pkg::SND_TONE_BIT] ? 32'(TONE_HI_HALF - 1)
                      : 32'(TONE_LO_HALF - 1);

  // Register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tickPeriod_reg     <= touch_timing_pkg::TICK_RESET;
      sampleInterval_reg <= touch_timing_pkg::SAMPLE_RESET;
      sounder_reg        <= touch_timing_pkg::SOUNDER_RESET;
      sleep_reg          <= touch_timing_pkg::SLEEP_RESET;
    end
    else if (regWrEn && busOpen)
    begin
      case (regAddr)
        touch_timing_pkg::ADDR_TICK:
          tickPeriod_reg <= regWrData & touch_timing_pkg::TICK_MASK;
        touch_timing_pkg::ADDR_SAMPLE:
          sampleInterval_reg <= regWrData;
        touch_timing_pkg::ADDR_SOUNDER:
          sounder_reg <= regWrData & touch_timing_pkg::SOUNDER_MASK;
        touch_timing_pkg::ADDR_SLEEP:
          sleep_reg <= regWrData;
        default:
          sleep_reg <= sleep_reg;
      endcase
    end
  end

  // Read answer strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regRdValid <= 1'b0;
    else
      regRdValid <= regRdEn && busOpen;
  end

  // Register reads
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else
    begin
      case (regAddr)
        touch_timing_pkg::ADDR_TICK:    regRdData <= tickPeriod_reg & touch_timing_pkg::TICK_MASK;
        touch_timing_pkg::ADDR_SAMPLE:  regRdData <= sampleInterval_reg;
        touch_timing_pkg::ADDR_SOUNDER: regRdData <= sounder_reg & touch_timing_pkg::SOUNDER_MASK;
        touch_timing_pkg::ADDR_SLEEP:   regRdData <= sleep_reg;
        default:                        regRdData <= 8'h00;
      endcase
    end
  end

  // Millisecond prescaler
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      msCount_reg  <= 32'h0;
      msStrobe_reg <= 1'b0;
    end
    else if (msCount_reg == 32'(MS_CYCLES - 1))
    begin
      msCount_reg  <= 32'h0;
      msStrobe_reg <= 1'b1;
    end
    else
    begin
      msCount_reg  <= msCount_reg + 32'h1;
      msStrobe_reg <= 1'b0;
    end
  end

  // Base tick
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tickMs_reg   <= 6'h0;
      tickLoad_reg <= 6'(touch_timing_pkg::TICK_BASE_MS);
      tickPulse    <= 1'b0;
    end
    else if (msStrobe_reg && tickMs_reg == tickLoad_reg - 6'h1)
    begin
      tickMs_reg   <= 6'h0;
      tickLoad_reg <= 6'(tickPeriod_reg[4:0]) + 6'(touch_timing_pkg::TICK_BASE_MS);
      tickPulse    <= 1'b1;
    end
    else
    begin
      tickMs_reg <= msStrobe_reg ? tickMs_reg + 6'h1 : tickMs_reg;
      tickPulse  <= 1'b0;
    end
  end

  // Touch sample interval
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sampleCount_reg <= 6'h0;
      samplePulse     <= 1'b0;
    end
    else if (sampleNow)
    begin
      sampleCount_reg <= 6'h0;
      samplePulse     <= !asleep;
    end
    else
    begin
      sampleCount_reg <= tickPulse ? sampleCount_reg + 6'h1 : sampleCount_reg;
      samplePulse     <= 1'b0;
    end
  end

  // Sleep duration decode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sleepDur_reg <= touch_timing_pkg::SLEEP_DUR_RESET;
    else if (regWrEn && busOpen && regAddr == touch_timing_pkg::ADDR_SLEEP)
      sleepDur_reg <= sleepLen(regWrData[3:0], sleepDur_reg);
  end

  // Power state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      powerState_reg <= PWR_AWAKE;
      asleep         <= 1'b0;
    end
    else
    begin
      case (powerState_reg)
        PWR_AWAKE:
          if (idleExpire)
          begin
            powerState_reg <= PWR_ASLEEP;
            asleep         <= 1'b1;
          end
        PWR_ASLEEP:
          if (sleepDone)
          begin
            powerState_reg <= PWR_AWAKE;
            asleep         <= 1'b0;
          end
        default:
        begin
          powerState_reg <= PWR_AWAKE;
          asleep         <= 1'b0;
        end
      endcase
    end
  end

  // Idle timeout count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      idleCount_reg <= 7'h0;
    else if (powerState_reg != PWR_AWAKE || idleHold || idleExpire)
      idleCount_reg <= 7'h0;
    else if (sampleNow)
      idleCount_reg <= idleCount_reg + 7'h1;
  end

  // Sleep duration count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sleepCount_reg <= 7'h0;
    else if (powerState_reg != PWR_ASLEEP || sleepDone)
      sleepCount_reg <= 7'h0;
    else if (sampleNow)
      sleepCount_reg <= sleepCount_reg + 7'h1;
  end

  // Click timing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clicking_reg <= 1'b0;
      clickMs_reg  <= 5'h0;
    end
    else if (!sounder_reg[touch_timing_pkg::SND_EN_BIT])
    begin
      clicking_reg <= 1'b0;
      clickMs_reg  <= 5'h0;
    end
    else if (!clicking_reg)
    begin
      clicking_reg <= rotaryTouch && touchClickEnable;
      clickMs_reg  <= 5'h0;
    end
    else if (msStrobe_reg)
    begin
      if (clickMs_reg == clickLast)
        clicking_reg <= 1'b0;
      clickMs_reg <= clickMs_reg + 5'h1;
    end
  end

  // Tone generator
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      toneCount_reg <= 32'h0;
      sounderOut    <= 1'b0;
    end
    else if (!sounder_reg[touch_timing_pkg::SND_EN_BIT] || !clicking_reg)
    begin
      toneCount_reg <= 32'h0;
      sounderOut    <= 1'b0;
    end
    else if (toneCount_reg >= toneLast)
    begin
      toneCount_reg <= 32'h0;
      sounderOut    <= !sounderOut;
    end
    else
      toneCount_reg <= toneCount_reg + 32'h1;
  end
endmodule

// ===== test/host_model.sv
// Host model issuing register strobes
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn
);
  initial {regAddr, regWrEn, regWrData, regRdEn} = '0;
  task wr(input logic [7:0] a, x);
    @(negedge clk);
    {regAddr, regWrData, regWrEn} = {a, x, 1'b1};
    @(negedge clk);
    {regWrData, regWrEn} = {~x, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] x, output logic v);
    @(negedge clk);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge clk);
    {x, v, regRdEn} = {regRdData, regRdValid, 1'b0};
  endtask
endmodule

// ===== test/touch_timing_props.sv
// Port assertions for the configuration block
`timescale 1ns/100ps
module touch_timing_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       regRdEn,
  input wire logic       stayAwake,
  input wire logic       wakePin,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic       tickPulse,
  input wire logic       samplePulse,
  input wire logic       sounderOut,
  input wire logic       asleep
);
  logic sndEn_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sndEn_reg <= 1'b0;
    else if (regWrEn && regAddr == touch_timing_pkg::ADDR_SOUNDER && (!asleep || wakePin))
      sndEn_reg <= regWrData[0];
  a_read_answered: assert property (regRdEn && (!asleep || wakePin) |=> regRdValid)
    else $error("Read not answered");
  a_read_refused: assert property (regRdEn && asleep && !wakePin |=> !regRdValid)
    else $error("Read answered asleep");
  a_tick_spacing: assert property (tickPulse |=> !tickPulse [*8])
    else $error("Ticks too close");
  a_sample_on_tick: assert property (samplePulse |-> $past(tickPulse))
    else $error("Sample without tick");
  a_tick_upper_zero: assert property (regRdValid && $past(regAddr) == touch_timing_pkg::ADDR_TICK
    |-> regRdData[7:5] == 3'h0) else $error("Tick upper bits set");
  a_snd_upper_zero: assert property (regRdValid && $past(regAddr) == touch_timing_pkg::ADDR_SOUNDER
    |-> regRdData[7:3] == 5'h00) else $error("Sounder upper bits set");
  a_snd_gated: assert property ((!sndEn_reg) [*2] |-> !sounderOut)
    else $error("Tone while disabled");
  a_stay_awake: assert property (stayAwake && !asleep |=> !asleep)
    else $error("Slept while held awake");
  a_sleep_quiet: assert property (asleep && $past(asleep) |-> !samplePulse)
    else $error("Sample while asleep");
endmodule

// ===== test/touch_timing_sounder_config_tb.sv
// Bench for the timing and sounder configuration block
`timescale 1ns/100ps
module touch_timing_sounder_config_tb;
  logic       clk = 1'b0, nrst = 1'b0, touchClickEnable = 1'b0;
  logic       stayAwake = 1'b0, wakePin = 1'b0, rotaryTouch = 1'b0, activity = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic       regWrEn, regRdEn, regRdValid, v, tickPulse, samplePulse, sounderOut, asleep;
  int         n_mismatch = 0, cmp_count = 0, n, t, s;
  always #4 clk = ~clk;
  touch_timing_sounder_config #(.MS_CYCLES(10), .TONE_LO_HALF(4), .TONE_HI_HALF(2)) touch_timing_sounder_config_i (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .touchClickEnable(touchClickEnable), .stayAwake(stayAwake), .wakePin(wakePin), .activity(activity),
    .rotaryTouch(rotaryTouch), .regRdData(regRdData), .regRdValid(regRdValid), .tickPulse(tickPulse),
    .samplePulse(samplePulse), .sounderOut(sounderOut), .asleep(asleep));
  host_model host_model_i (.clk(clk), .regRdData(regRdData), .regRdValid(regRdValid), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
  task end_of_test;
    $display("Mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    n_mismatch += int'(g !== e);
    if (g !== e)
      $display("Error at %0t: got %0h, expected %0h", $time, g, e);
  endtask
  task rdc(input logic [7:0] a, e);
    host_model_i.rd(a, d, v);
    chk({d, 7'h0, v}, {e, 8'h01});
  endtask
  task watch(input int w, m);
    logic p;
    int q;
    {t, s, q} = '0;
    p = sounderOut;
    repeat (m)
    begin
      @(negedge clk);
      q++;
      if ((w == 0 ? tickPulse : w == 1 ? samplePulse : sounderOut !== p) === 1'b1)
      begin
        s = t == 1 ? q : s;
        t++;
        q = 0;
      end
      p = sounderOut;
    end
  endtask
  task slp(input logic lv);
    n = 0;
    while (asleep !== lv && n < 6000) @(negedge clk) n++;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    for (int a = 5; a < 9; a++)
      rdc(8'(a), 8'h00);
    rdc(8'h10, 8'h00);
    host_model_i.wr(8'h05, 8'hff);
    rdc(8'h05, 8'h1f);
    host_model_i.wr(8'h07, 8'hfa);
    rdc(8'h07, 8'h02);
    host_model_i.wr(8'h05, 8'h00);
    watch(0, 500);
    chk(s, 50);
    host_model_i.wr(8'h05, 8'h1f);
    watch(0, 800);
    chk(s, 360);
    host_model_i.wr(8'h05, 8'h01);
    host_model_i.wr(8'h06, 8'h02);
    watch(1, 800);
    chk(s, 180);
    for (int c = 0; c < 6; c++)
    begin
      host_model_i.wr(8'h07, 8'(c < 4 ? 2 * c + 1 : 26 - 5 * c));
      touchClickEnable = c != 5;
      @(negedge clk) rotaryTouch = 1'b1;
      @(negedge clk) rotaryTouch = 1'b0;
      watch(2, 300);
      if (c < 4)
      begin
        chk(s, c[0] ? 2 : 4);
        chk(t * s > (c[1] ? 190 : 90) - 2 * s && t * s <= (c[1] ? 200 : 100) + 2 * s, 1);
      end
      else
        chk(t, 0);
    end
    host_model_i.wr(8'h05, 8'h00);
    host_model_i.wr(8'h06, 8'h00);
    chk(asleep, 0);
    host_model_i.wr(8'h08, 8'h12);
    repeat (200) @(negedge clk);
    activity = 1'b1;
    @(negedge clk) activity = 1'b0;
    slp(1'b1);
    chk(n > 330 && n < 480, 1);
    slp(1'b0);
    chk(n > 440 && n < 560, 1);
    slp(1'b1);
    host_model_i.rd(8'h08, d, v);
    chk(v, 0);
    {wakePin, stayAwake} = 2'b11;
    rdc(8'h08, 8'h12);
    wakePin = 1'b0;
    slp(1'b1);
    chk(asleep, 0);
    stayAwake = 1'b0;
    host_model_i.wr(8'h08, 8'h1b);
    host_model_i.wr(8'h08, 8'h1c);
    slp(1'b1);
    slp(1'b0);
    chk(n > 4940 && n < 5060, 1);
    end_of_test;
  end
  initial
  begin
    #300000;
    n_mismatch++;
    end_of_test;
  end
endmodule
bind touch_timing_sounder_config touch_timing_props touch_timing_props_i (.clk(clk), .nrst(nrst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .stayAwake(stayAwake), .wakePin(wakePin),
  .regRdData(regRdData), .regRdValid(regRdValid), .tickPulse(tickPulse), .samplePulse(samplePulse),
  .sounderOut(sounderOut), .asleep(asleep));
